//--- hdl/slcd_ctrl.sv
// Segment display driver control: registers, segment memory, frame timing
// and per-pin drive levels. Assumes power mode inputs come from logic on
// CLK_SYS and that an analog stage turns level codes into bias voltages.
//
// Notes on behaviour
// - Deepest stop modes suspend all display operation.
// - Stop3 with stop halt bit set halts display.
// - Stop3 with stop halt bit clear keeps driving.
// - Wait with wait halt bit set halts display.
// - Wait with wait halt bit clear keeps driving.
// - Blinking continues in wait and stop3 while active.
// - Segment memory frozen during wait and stop3.
// - Duty field picks shared pin role.
// - Duty codes: reserved, half, third, quarter.
// - All plane outputs high impedance after reset.
// - Four backplanes/forty fronts or three/forty-one.
// - Per-segment blink enable, programmable blink rate.
// - Frame event pulse at each frame boundary.
// - Enable clear disables planes and stops clocks; here the tick divider keeps running.
// - Waveform select bit: normal or low-power.
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module slcd_ctrl #(
	parameter int ADDR_W  = 8,
	parameter int SYS_DIV = slcd_pkg::SYS_REF_DIV
) (
	// Clock and reset
	input  wire logic                                    CLK_SYS,
	input  wire logic                                    RESETN,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0]                       S_AXI_AWADDR,
	input  wire logic                                    S_AXI_AWVALID,
	output logic                                         S_AXI_AWREADY,
	input  wire logic [31:0]                             S_AXI_WDATA,
	input  wire logic [3:0]                              S_AXI_WSTRB,
	input  wire logic                                    S_AXI_WVALID,
	output logic                                         S_AXI_WREADY,
	// AXI4-Lite write response
	output logic [1:0]                                   S_AXI_BRESP,
	output logic                                         S_AXI_BVALID,
	input  wire logic                                    S_AXI_BREADY,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0]                       S_AXI_ARADDR,
	input  wire logic                                    S_AXI_ARVALID,
	output logic                                         S_AXI_ARREADY,
	output logic [31:0]                                  S_AXI_RDATA,
	output logic [1:0]                                   S_AXI_RRESP,
	output logic                                         S_AXI_RVALID,
	input  wire logic                                    S_AXI_RREADY,
	// Processor power modes
	input  wire logic                                    MODE_WAIT,
	input  wire logic                                    MODE_STOP3,
	input  wire logic                                    MODE_STOP12,
	// External reference clock pin
	input  wire logic                                    REF_CLK_PIN,
	// Panel drive
	output slcd_pkg::slcd_lvl_t [slcd_pkg::NUM_BP-1:0]   BP_LEVEL,
	output logic [slcd_pkg::NUM_BP-1:0]                  BP_OE,
	output slcd_pkg::slcd_lvl_t [slcd_pkg::NUM_FP-1:0]   FP_LEVEL,
	output logic [slcd_pkg::NUM_FP-1:0]                  FP_OE,
	output slcd_pkg::slcd_lvl_t                          SH_LEVEL,
	output logic                                         SH_OE,
	// Frame event
	output logic                                         FRAME_EVT
);
	import slcd_pkg::*;

	localparam int NWORD = 2 ** (ADDR_W - 2);

	if (ADDR_W < 8 || ADDR_W > 16) begin : g_bad_addr
		$error("ADDR_W must lie between 8 and 16");
	end

	// ******************************************
	// Declarations
	// ******************************************
	slcd_ctrl0_s             ctrl0_r;
	slcd_ctrl1_s             ctrl1_r;
	slcd_blink_s             blink_r;
	logic [SEG_CNT-1:0][7:0] seg_r;
	logic [SEG_CNT-1:0]      fpen_r;

	logic                    aw_held_r;
	logic                    w_held_r;
	logic [ADDR_W-3:0]       widx_r;
	logic [31:0]             wdata_r;
	logic [3:0]              wstrb_r;
	logic                    wr_fire;
	logic [31:0]             wr_word;
	logic [ADDR_W-3:0]       ridx;
	logic [NWORD-1:0][31:0]  view;
	logic [NWORD-1:0]        hit;

	logic                    tick;
	logic                    halt_req;
	logic                    cfg_ok;
	logic                    running;
	logic                    frame_end;
	logic                    halted_r;
	logic                    lp_act_r;
	logic [1:0]              phase_r;
	logic                    half_r;
	logic [7:0]              blink_cnt_r;
	logic                    blink_blank;
	logic                    frame_flag_r;
	logic                    sh_is_bp;
	logic [SEG_CNT-1:0]      seg_on;

	// ******************************************
	// Level coding
	// ******************************************
	// Bias is chosen so that lit segments see 3 steps and dark ones 1 step
	function automatic slcd_lvl_t bp_lvl(input logic act, input logic half);
		if (act) begin
			bp_lvl = half ? LVL_V0 : LVL_V3;
		end else begin
			bp_lvl = half ? LVL_V2 : LVL_V1;
		end
	endfunction : bp_lvl

	function automatic slcd_lvl_t fp_lvl(input logic on, input logic half);
		if (on) begin
			fp_lvl = half ? LVL_V3 : LVL_V0;
		end else begin
			fp_lvl = half ? LVL_V1 : LVL_V2;
		end
	endfunction : fp_lvl

	function automatic logic [31:0] merge(input logic [31:0] old,
	                                      input logic [31:0] nw,
	                                      input logic [3:0]  strb);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				merge[8*b +: 8] = nw[8*b +: 8];
			end
		end
	endfunction : merge

	// ******************************************
	// Register view
	// ******************************************
	always_comb begin
		view = '0;
		hit  = '0;
		view[IDX_CTRL0]  = {24'h000000, ctrl0_r};
		view[IDX_CTRL1]  = {24'h000000, ctrl1_r};
		view[IDX_BLINK]  = {24'h000000, blink_r};
		view[IDX_STATUS] = {25'h0000000, half_r, phase_r, lp_act_r, blink_blank,
		                    frame_flag_r, running};
		view[IDX_FPEN0]  = fpen_r[31:0];
		view[IDX_FPEN1]  = {23'h000000, fpen_r[SEG_CNT-1:32]};
		for (int k = 0; k <= IDX_FPEN1; k++) begin
			hit[k] = 1'b1;
		end
		for (int i = 0; i < SEG_CNT; i++) begin
			view[IDX_SEG + i] = {24'h000000, seg_r[i]};
			hit[IDX_SEG + i]  = 1'b1;
		end
	end

	// ******************************************
	// AXI4-Lite write channel
	// ******************************************
	assign S_AXI_AWREADY = !aw_held_r && !S_AXI_BVALID;
	assign S_AXI_WREADY  = !w_held_r && !S_AXI_BVALID;
	assign wr_fire       = aw_held_r && w_held_r && !S_AXI_BVALID;
	assign wr_word       = merge(view[widx_r], wdata_r, wstrb_r);

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			aw_held_r <= 1'b0;
			widx_r    <= '0;
		end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_held_r <= 1'b1;
			widx_r    <= S_AXI_AWADDR[ADDR_W-1:2];
		end else if (wr_fire) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			w_held_r <= 1'b0;
			wdata_r  <= 32'h00000000;
			wstrb_r  <= 4'h0;
		end else if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_held_r <= 1'b1;
			wdata_r  <= S_AXI_WDATA;
			wstrb_r  <= S_AXI_WSTRB;
		end else if (wr_fire) begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= RESP_OKAY;
		end else if (wr_fire) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP  <= hit[widx_r] ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// ******************************************
	// AXI4-Lite read channel
	// ******************************************
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign ridx          = S_AXI_ARADDR[ADDR_W-1:2];

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h00000000;
			S_AXI_RRESP  <= RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA  <= view[ridx];
			S_AXI_RRESP  <= hit[ridx] ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	// ******************************************
	// Control registers
	// ******************************************
	// Duty and prescale are not guarded while enabled; changing them live flickers
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			ctrl0_r <= slcd_ctrl0_s'(CTRL0_RST);
			ctrl1_r <= slcd_ctrl1_s'(CTRL1_RST);
			blink_r <= slcd_blink_s'(BLINK_RST);
		end else if (wr_fire) begin
			if (int'(widx_r) == IDX_CTRL0) begin
				ctrl0_r <= slcd_ctrl0_s'(wr_word[7:0] & CTRL0_WMASK);
			end
			if (int'(widx_r) == IDX_CTRL1) begin
				ctrl1_r <= slcd_ctrl1_s'(wr_word[7:0] & CTRL1_WMASK);
			end
			if (int'(widx_r) == IDX_BLINK) begin
				blink_r <= slcd_blink_s'(wr_word[7:0] & BLINK_WMASK);
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			fpen_r <= '0;
		end else if (wr_fire && int'(widx_r) == IDX_FPEN0) begin
			fpen_r[31:0] <= wr_word;
		end else if (wr_fire && int'(widx_r) == IDX_FPEN1) begin
			fpen_r[SEG_CNT-1:32] <= wr_word[SEG_CNT-33:0];
		end
	end

	// Frame flag: a new frame end wins over a write-one clear
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			frame_flag_r <= 1'b0;
		end else if (frame_end) begin
			frame_flag_r <= 1'b1;
		end else if (wr_fire && int'(widx_r) == IDX_STATUS && wstrb_r[0]
		             && wdata_r[ST_FRAME]) begin
			frame_flag_r <= 1'b0;
		end
	end

	// ******************************************
	// Segment memory
	// ******************************************
	// Low nibble: lit per backplane; high nibble: blink per backplane
	for (genvar i = 0; i < SEG_CNT; i++) begin : g_seg
		always_ff @(posedge CLK_SYS or negedge RESETN) begin
			if (!RESETN) begin
				seg_r[i] <= 8'h00;
			end else if (wr_fire && int'(widx_r) == IDX_SEG + i
			             && !MODE_WAIT && !MODE_STOP3) begin
				seg_r[i] <= wr_word[7:0];
			end
		end
		assign seg_on[i] = seg_r[i][phase_r]
		                   && !(blink_blank && seg_r[i][{1'b1, phase_r}]);
	end

	// ******************************************
	// Frame sequencer
	// ******************************************
	slcd_tick #(
		.SYS_DIV (SYS_DIV)
	) u_tick (
		.CLK_SYS  (CLK_SYS),
		.RESETN   (RESETN),
		.REF_PIN  (REF_CLK_PIN),
		.REF_SEL  (ctrl1_r.ref_sel),
		.PRESCALE (ctrl0_r.prescale),
		.TICK     (tick)
	);

	assign halt_req  = (MODE_STOP3 && ctrl1_r.stop_halt)
	                   || (MODE_WAIT && ctrl1_r.wait_halt);
	assign cfg_ok    = ctrl0_r.enable && ctrl0_r.duty != DUTY_RSVD
	                   && !MODE_STOP12;
	assign running   = cfg_ok && !halted_r;
	assign frame_end = running && tick && phase_r == ctrl0_r.duty
	                   && (lp_act_r || half_r);

	// Halting waits for the frame to close; resuming needs no boundary
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			halted_r <= 1'b0;
		end else if (!cfg_ok) begin
			halted_r <= halt_req;
		end else if (frame_end) begin
			halted_r <= halt_req;
		end else if (halted_r && !halt_req) begin
			halted_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			lp_act_r <= 1'b0;
		end else if (!running || frame_end) begin
			lp_act_r <= ctrl0_r.waveform_select_bit;
		end
	end

	// Normal: polarity flips inside each phase. Low power: once per sub-frame
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			phase_r <= 2'h0;
			half_r  <= 1'b0;
		end else if (!running) begin
			phase_r <= 2'h0;
			half_r  <= 1'b0;
		end else if (frame_end) begin
			phase_r <= 2'h0;
			half_r  <= ctrl0_r.waveform_select_bit ? !half_r : 1'b0;
		end else if (tick && (lp_act_r || half_r)) begin
			phase_r <= phase_r + 2'h1;
			half_r  <= lp_act_r ? half_r : 1'b0;
		end else if (tick) begin
			half_r  <= 1'b1;
		end
	end

	// Blink keeps counting frames in any mode where the panel is driven
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			blink_cnt_r <= 8'h00;
		end else if (!ctrl0_r.enable) begin
			blink_cnt_r <= 8'h00;
		end else if (frame_end) begin
			blink_cnt_r <= blink_cnt_r + 8'h01;
		end
	end

	assign blink_blank = blink_r.enable && blink_cnt_r[blink_r.rate];

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			FRAME_EVT <= 1'b0;
		end else begin
			FRAME_EVT <= frame_end;
		end
	end

	// ******************************************
	// Pin drive
	// ******************************************
	assign sh_is_bp = ctrl0_r.duty == DUTY_QUARTER;

	for (genvar j = 0; j < NUM_BP; j++) begin : g_bp
		always_ff @(posedge CLK_SYS or negedge RESETN) begin
			if (!RESETN) begin
				BP_OE[j]    <= 1'b0;
				BP_LEVEL[j] <= LVL_V0;
			end else begin
				BP_OE[j]    <= running && 2'(j) <= ctrl0_r.duty;
				BP_LEVEL[j] <= bp_lvl(phase_r == 2'(j), half_r);
			end
		end
	end

	for (genvar i = 0; i < NUM_FP; i++) begin : g_fp
		always_ff @(posedge CLK_SYS or negedge RESETN) begin
			if (!RESETN) begin
				FP_OE[i]    <= 1'b0;
				FP_LEVEL[i] <= LVL_V0;
			end else begin
				FP_OE[i]    <= running && fpen_r[i];
				FP_LEVEL[i] <= fp_lvl(seg_on[i], half_r);
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			SH_OE    <= 1'b0;
			SH_LEVEL <= LVL_V0;
		end else begin
			SH_OE    <= running && (sh_is_bp || fpen_r[NUM_FP]);
			SH_LEVEL <= sh_is_bp ? bp_lvl(phase_r == 2'h3, half_r)
			                     : fp_lvl(seg_on[NUM_FP], half_r);
		end
	end

	// ******************************************
	// Assertions
	// ******************************************
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);

	sequence s_frame_close;
		frame_end ##1 FRAME_EVT;
	endsequence

	sequence s_quiet_pins;
		BP_OE == '0 && FP_OE == '0 && !SH_OE;
	endsequence

	a_deep_stop_off: assert property (MODE_STOP12 |=> s_quiet_pins)
		else $error("Pins driven in deep stop");
	a_stop3_halts: assert property (frame_end && MODE_STOP3 && ctrl1_r.stop_halt
	                                |=> !running)
		else $error("Display kept running in halted stop3");
	a_stop3_runs: assert property (running && MODE_STOP3 && !ctrl1_r.stop_halt
	                               && !MODE_WAIT && $stable(ctrl0_r) |=> running)
		else $error("Display stopped in stop3 without halt");
	a_wait_halts: assert property (frame_end && MODE_WAIT && ctrl1_r.wait_halt
	                               |=> !running ##1 s_quiet_pins)
		else $error("Display kept running in halted wait");
	a_wait_runs: assert property (running && MODE_WAIT && !ctrl1_r.wait_halt
	                              && !MODE_STOP3 && $stable(ctrl0_r) |=> running)
		else $error("Display stopped in wait without halt");
	a_blink_counts: assert property (frame_end && ctrl0_r.enable
	                                 |=> blink_cnt_r == $past(blink_cnt_r) + 8'h01)
		else $error("Blink counter missed a frame");
	a_mem_frozen: assert property (MODE_WAIT || MODE_STOP3 |=> $stable(seg_r))
		else $error("Segment memory changed in low power");
	a_shared_role: assert property (running && ctrl0_r.duty == DUTY_QUARTER
	                                ##1 $stable(ctrl0_r.duty) |-> SH_OE)
		else $error("Shared pin not driven as backplane");
	a_frame_event: assert property (frame_end |-> s_frame_close)
		else $error("Frame event missing");
	a_disable_quiet: assert property (!ctrl0_r.enable |=> s_quiet_pins
	                                  and (phase_r == 2'h0))
		else $error("Outputs active while disabled");
	a_lp_boundary: assert property (running && !frame_end |=> $stable(lp_act_r))
		else $error("Waveform type changed mid frame");

endmodule : slcd_ctrl

//--- hdl/slcd_pkg.sv
// Shared constants and types of the segment display driver control block.
// Assumes a single 100 MHz system clock and an AXI4-Lite register master.
package slcd_pkg;

	// ******************************************
	// Clocking and timing
	// ******************************************
	localparam int CLK_SYS_HZ  = 100_000_000;
	localparam int REF_HZ      = 32_768;
	// Bus clock cycles per reference clock period, rounded down
	localparam int SYS_REF_DIV = CLK_SYS_HZ / REF_HZ;
	localparam int BASE_DIV    = 16;
	localparam int PRE_W       = 11;

	// ******************************************
	// Panel geometry
	// ******************************************
	localparam int NUM_BP  = 3;
	localparam int NUM_FP  = 40;
	localparam int SEG_CNT = NUM_FP + 1;

	// ******************************************
	// Register word indices (byte address = 4 * index)
	// ******************************************
	localparam int IDX_CTRL0  = 0;
	localparam int IDX_CTRL1  = 1;
	localparam int IDX_BLINK  = 2;
	localparam int IDX_STATUS = 3;
	localparam int IDX_FPEN0  = 4;
	localparam int IDX_FPEN1  = 5;
	localparam int IDX_SEG    = 16;

	// Reset values and writable bit masks
	localparam logic [7:0] CTRL0_RST   = 8'h03;
	localparam logic [7:0] CTRL0_WMASK = 8'hFB;
	localparam logic [7:0] CTRL1_RST   = 8'h00;
	localparam logic [7:0] CTRL1_WMASK = 8'h07;
	localparam logic [7:0] BLINK_RST   = 8'h00;
	localparam logic [7:0] BLINK_WMASK = 8'h87;

	// Status bit positions
	localparam int ST_RUN   = 0;
	localparam int ST_FRAME = 1;
	localparam int ST_BLINK = 2;
	localparam int ST_LP    = 3;
	localparam int ST_PH_LO = 4;
	localparam int ST_HALF  = 6;

	// Duty codes
	localparam logic [1:0] DUTY_RSVD    = 2'h0;
	localparam logic [1:0] DUTY_QUARTER = 2'h3;

	// Drive levels: ground and the three bias rails
	typedef logic [1:0] slcd_lvl_t;
	localparam slcd_lvl_t LVL_V0 = 2'h0;
	localparam slcd_lvl_t LVL_V1 = 2'h1;
	localparam slcd_lvl_t LVL_V2 = 2'h2;
	localparam slcd_lvl_t LVL_V3 = 2'h3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ******************************************
	// Register layouts
	// ******************************************
	typedef struct packed {
		logic       enable;
		logic       waveform_select_bit;
		logic [2:0] prescale;
		logic       rsvd;
		logic [1:0] duty;
	} slcd_ctrl0_s;

	typedef struct packed {
		logic [4:0] rsvd;
		logic       ref_sel;
		logic       wait_halt;
		logic       stop_halt;
	} slcd_ctrl1_s;

	typedef struct packed {
		logic       enable;
		logic [3:0] rsvd;
		logic [2:0] rate;
	} slcd_blink_s;

endpackage : slcd_pkg

//--- hdl/slcd_tick.sv
// Waveform base tick generator of the segment display driver.
// Assumes REF_PIN is asynchronous to CLK_SYS and much slower than it.
`timescale 1ns/1ps
module slcd_tick #(
	parameter int SYS_DIV = slcd_pkg::SYS_REF_DIV
) (
	// Clock and reset
	input  wire logic       CLK_SYS,
	input  wire logic       RESETN,
	// Source selection and divider
	input  wire logic       REF_PIN,
	input  wire logic       REF_SEL,
	input  wire logic [2:0] PRESCALE,
	// Base tick, one cycle
	output logic            TICK
);
	import slcd_pkg::*;

	localparam int SDW = $clog2(SYS_DIV);

	if (SYS_DIV < 2) begin : g_bad_div
		$error("SYS_DIV must be at least 2");
	end

	logic [2:0]       ref_sync_r;
	logic [SDW-1:0]   sys_cnt_r;
	logic [PRE_W-1:0] pre_cnt_r;
	logic [PRE_W:0]   pre_lim;
	logic             src_pulse;
	logic             at_lim;

	// ******************************************
	// Reference pin: two stages, then an edge stage
	// ******************************************
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			ref_sync_r <= 3'h0;
		end else begin
			ref_sync_r <= {ref_sync_r[1:0], REF_PIN};
		end
	end

	// Bus-derived stand-in for the reference when it is not selected
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			sys_cnt_r <= '0;
		end else if (sys_cnt_r == SDW'(SYS_DIV - 1)) begin
			sys_cnt_r <= '0;
		end else begin
			sys_cnt_r <= sys_cnt_r + SDW'(1);
		end
	end

	assign src_pulse = REF_SEL ? (ref_sync_r[1] && !ref_sync_r[2])
	                           : (sys_cnt_r == SDW'(SYS_DIV - 1));
	assign pre_lim   = (PRE_W + 1)'(BASE_DIV) << PRESCALE;
	// A shrinking prescale never strands the counter above its limit
	assign at_lim    = ({1'b0, pre_cnt_r} >= pre_lim - (PRE_W + 1)'(1));

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			pre_cnt_r <= '0;
		end else if (src_pulse) begin
			pre_cnt_r <= at_lim ? '0 : pre_cnt_r + PRE_W'(1);
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			TICK <= 1'b0;
		end else begin
			TICK <= src_pulse && at_lim;
		end
	end

endmodule : slcd_tick

//--- test/slcd_glass.sv
// Passive model of the segment glass on the far side of the plane pins.
// Assumes level codes and output enables straight from the control block.
`timescale 1ns/1ps
module slcd_glass
	import slcd_pkg::*;
(
	// Plane pins
	input wire slcd_lvl_t [NUM_BP-1:0] BP_LEVEL,
	input wire logic [NUM_BP-1:0]      BP_OE,
	input wire slcd_lvl_t [NUM_FP-1:0] FP_LEVEL,
	input wire logic [NUM_FP-1:0]      FP_OE,
	// Segment on backplane 0, frontplane 0 sees full bias
	output logic                       LIT0
);
	// A floating plane carries no field; only a full three-step swing lights it
	assign LIT0 = BP_OE[0] && FP_OE[0]
	              && ((BP_LEVEL[0] == LVL_V3 && FP_LEVEL[0] == LVL_V0)
	              || (BP_LEVEL[0] == LVL_V0 && FP_LEVEL[0] == LVL_V3));
endmodule : slcd_glass

//--- test/test_segment_lcd_driver_control.sv
// Self-checking bench of the display driver control block.
// Assumes a shortened reference divider and bus ready always high.
`timescale 1ns/1ps
module test_segment_lcd_driver_control;
	import slcd_pkg::*;
	logic clk = 0, rstn = 0, awv = 0, wv = 0, arv = 0, mw = 0, ms3 = 0, ms12 = 0, refc = 0;
	logic [7:0] aw = 0, ar = 0;
	logic [31:0] wd = 0, rdd, fp;
	logic aw_r, w_r, b_v, ar_r, r_v, fe, sh_oe, lit0;
	logic [1:0] bs, rs;
	logic [NUM_BP-1:0] bp_oe;
	logic [NUM_FP-1:0] fp_oe;
	slcd_lvl_t [NUM_BP-1:0] bpl;
	slcd_lvl_t [NUM_FP-1:0] fpl;
	slcd_lvl_t shl;
	logic [33:0] q[$];
	logic [63:0] lc;
	int err_count = 0, checked = 0, seed = 65549, n;
	always #5 clk = ~clk;
	// Reference pin, toggled on the bus clock falling edges
	always #10 refc = ~refc;
	slcd_ctrl #(.SYS_DIV(2)) u_slcd_ctrl (.CLK_SYS(clk), .RESETN(rstn),
		.S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(aw_r), .S_AXI_WDATA(wd),
		.S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(w_r), .S_AXI_BRESP(bs),
		.S_AXI_BVALID(b_v), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(ar_r), .S_AXI_RDATA(rdd), .S_AXI_RRESP(rs), .S_AXI_RVALID(r_v),
		.S_AXI_RREADY(1'b1), .MODE_WAIT(mw), .MODE_STOP3(ms3), .MODE_STOP12(ms12),
		.REF_CLK_PIN(refc), .BP_LEVEL(bpl), .BP_OE(bp_oe), .FP_LEVEL(fpl), .FP_OE(fp_oe),
		.SH_LEVEL(shl), .SH_OE(sh_oe), .FRAME_EVT(fe));
	slcd_glass u_slcd_glass (.BP_LEVEL(bpl), .BP_OE(bp_oe), .FP_LEVEL(fpl), .FP_OE(fp_oe),
		.LIT0(lit0));
	task chk(input logic [63:0] s, input logic [63:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task tally_and_finish;
		if (err_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	// ******************************************
	// Bus master, responses noted in the queue
	// ******************************************
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic da, dw;
		q.push_back({e, 32'h0});
		aw <= a; wd <= d; awv <= 1; wv <= 1; da = 0; dw = 0;
		while (!(da && dw)) begin
			@(posedge clk);
			if (aw_r) begin da = 1; awv <= 0; end
			if (w_r) begin dw = 1; wv <= 0; end
		end
		do @(posedge clk); while (!b_v);
	endtask : wr
	task rd(input logic [7:0] a, input logic [33:0] e);
		q.push_back(e);
		ar <= a; arv <= 1;
		do @(posedge clk); while (!ar_r);
		arv <= 0;
		do @(posedge clk); while (!r_v);
	endtask : rd
	always @(posedge clk) if ((b_v || r_v) && q.size() > 0)
		chk(b_v ? {bs, 32'h0} : {rs, rdd}, q.pop_front());
	// Bounded wait for the next frame event
	// Always lets one edge pass, so an event from before the call is not taken
	task frm;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (n < 900 && !fe);
		chk({63'h0, fe}, 64'h1);
	endtask : frm
	// Cycles in which the glass sees segment 0 lit, over w cycles after a frame event
	task lit(input int w, input logic [63:0] e);
		frm();
		lc = 0;
		repeat (w) begin
			@(posedge clk);
			lc = lc + lit0;
		end
		chk(lc, e);
	endtask : lit
	function automatic logic [63:0] oe;
		oe = {bp_oe, fp_oe, sh_oe};
	endfunction : oe
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1;
		@(posedge clk);
		chk(oe(), 64'h0);
		rd(8'h00, {RESP_OKAY, 24'h0, CTRL0_RST});
		rd(8'h20, {RESP_SLVERR, 32'h0});
		fp = $random(seed) | 32'h1;
		wr(8'h10, fp, RESP_OKAY);
		wr(8'h14, 32'h1FF, RESP_OKAY);
		// Every duty code, quarter duty last so the display stays up
		for (int d = 0; d < 4; d++) begin
			wr(8'h00, 32'h80 | d, RESP_OKAY);
			if (d == 0) repeat (2) @(posedge clk);
			else frm();
			chk(oe(), d == 0 ? 64'h0 : {d[1], 2'h3, 8'hFF, fp, 1'b1});
		end
		wr(8'h40, 32'h15, RESP_OKAY);
		wr(8'h04, 32'h4, RESP_OKAY);
		ms3 <= 1;
		wr(8'h40, 32'hA, RESP_OKAY);
		rd(8'h40, {RESP_OKAY, 32'h15});
		frm();
		chk(oe(), {3'h7, 8'hFF, fp, 1'b1});
		lit(256, 2 * BASE_DIV * 2);
		ms3 <= 0;
		mw <= 1;
		frm();
		chk(oe(), {3'h7, 8'hFF, fp, 1'b1});
		wr(8'h08, 32'h80, RESP_OKAY);
		lit(512, 2 * BASE_DIV * 2);
		wr(8'h04, 32'h6, RESP_OKAY);
		for (n = 0; n < 900 && oe() != 0; n++) @(posedge clk);
		chk(oe(), 64'h0);
		mw <= 0;
		frm();
		ms12 <= 1;
		repeat (2) @(posedge clk);
		chk(oe(), 64'h0);
		ms12 <= 0;
		frm();
		wr(8'h00, 32'hC3, RESP_OKAY);
		lit(256, BASE_DIV * 2);
		wr(8'h00, 32'h03, RESP_OKAY);
		repeat (2) @(posedge clk);
		chk(oe(), 64'h0);
		tally_and_finish();
	end
	initial begin
		#300000;
		err_count++;
		tally_and_finish();
	end
endmodule : test_segment_lcd_driver_control
